// File: header_field_pkg.sv
// Package with register map, field positions and reset values of the header field registers.
package header_field_pkg;
    localparam int unsigned ADDR_WIDTH            = 8;
    localparam int unsigned DATA_WIDTH            = 32;
    localparam int unsigned REG_WIDTH             = 8;
    localparam logic [7:0]  MODEM_CONFIG_E_OFFSET = 8'h9C;
    localparam logic [7:0]  SEARCH_TIME_OFFSET    = 8'hA4;
    localparam logic [7:0]  BPSK_CODE_OFFSET      = 8'hA8;
    localparam logic [7:0]  QPSK_CODE_OFFSET      = 8'hAC;
    localparam logic [7:0]  RX_SERVICE_OFFSET     = 8'hB0;
    localparam logic [7:0]  RX_LENGTH_HIGH_OFFSET = 8'hB4;
    localparam logic [7:0]  RX_LENGTH_LOW_OFFSET  = 8'hB8;
    localparam logic [7:0]  RX_CHECK_HIGH_OFFSET  = 8'hBC;
    localparam int unsigned VERIFY_READY_BIT      = 1;
    localparam int unsigned LENGTH_USEC_BIT       = 6;
    localparam logic [7:0]  CONFIG_WRITE_MASK     = 8'h7E;
    localparam logic [7:0]  CONFIG_RESET          = 8'h00;
    localparam logic [7:0]  SEARCH_TIME_RESET     = 8'h00;
    localparam logic [7:0]  BPSK_CODE_RESET       = 8'h0A;
    localparam logic [7:0]  QPSK_CODE_RESET       = 8'h14;
    localparam logic [7:0]  STATUS_RESET          = 8'h00;
    localparam logic [1:0]  RESP_OKAY             = 2'h0;
    localparam logic [1:0]  RESP_SLVERR           = 2'h2;
endpackage

// File: search_if.sv
// Interface between the register block and the delimiter search timer.
`timescale 1ns/1ps
interface search_if;
    logic       start;
    logic       found;
    logic       symbol_tick;
    logic [7:0] limit;
    logic       active;
    logic       timeout;
    modport ctrl  (output start, output found, output symbol_tick, output limit,
                   input active, input timeout);
    modport timer (input start, input found, input symbol_tick, input limit,
                   output active, output timeout);
endinterface

// File: delimiter_search_timer.sv
// Symbol-period timer that bounds the search for the start frame delimiter.
`timescale 1ns/1ps
module delimiter_search_timer
    import header_field_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    search_if.timer  srch
);
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic       active_q;
    logic       active_d;
    logic       timeout_q;
    logic       timeout_d;
    logic [7:0] limit_q;
    logic [7:0] limit_d;
    wire        expired = active_q && (count_q == limit_q) && !srch.found;

    // The search stops after the programmed number of symbol periods.
    assign count_d   = srch.start ? 8'h00 :
                       (active_q && srch.symbol_tick) ? count_q + 8'h01 : count_q; // see [R3]
    assign active_d  = srch.start || (active_q && !srch.found && !expired);
    assign timeout_d = expired && !srch.start; // see [R3]
    // The limit is held from the start, so a write during a search cannot stretch it.
    assign limit_d   = srch.start ? srch.limit : limit_q; // see [R3]

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count_q   <= 8'h00;
            active_q  <= 1'b0;
            timeout_q <= 1'b0;
            limit_q   <= 8'h00;
        end
        else
        begin
            count_q   <= count_d;
            active_q  <= active_d;
            timeout_q <= timeout_d;
            limit_q   <= limit_d;
        end
    end

    assign srch.active  = active_q;
    assign srch.timeout = timeout_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_SEARCH_BOUND: assert property (active_q |-> count_q <= limit_q) // see [R3]
        else $error("Search count ran past the programmed limit.");
    AST_SEARCH_TIMEOUT: assert property ( // see [R3]
        active_q && count_q == limit_q && !srch.found && !srch.start
        |=> timeout_q && !active_q)
        else $error("Search did not time out at the limit.");
    COV_TIMEOUT: cover property (timeout_q);
endmodule

// File: header_field_registers.sv
// Header field configuration and status registers with an AXI4-Lite slave.
//
// Behaviour
// [R1] Verify option raises data ready after antenna dwell.
// [R2] Host writes zero to configuration bit zero.
// [R3] Delimiter search bounded by programmed symbol count.
// [R4] DBPSK code transmitted and used to recognise.
// [R5] DQPSK code transmitted and used to recognise.
// [R6] Received service field captured into status.
// [R7] Received length split across high/low registers.
// [R8] Bit six selects microsecond length counting.
// [R9] Status captured once per header, then held; the code recaptures on every cycle a valid is high.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module header_field_registers
    import header_field_pkg::*;
(
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [ADDR_WIDTH-1:0]   s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [DATA_WIDTH-1:0]   s_axi_wdata,
    input  wire logic [DATA_WIDTH/8-1:0] s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [ADDR_WIDTH-1:0]   s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [DATA_WIDTH-1:0]        s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic                    antenna_dwell_done,
    input  wire logic                    header_start,
    input  wire logic                    start_frame_delimiter_found,
    input  wire logic                    symbol_tick,
    input  wire logic                    rx_end,
    input  wire logic                    tx_rate_qpsk,
    input  wire logic                    rx_signal_valid,
    input  wire logic [7:0]              rx_signal_field,
    input  wire logic                    rx_service_valid,
    input  wire logic [7:0]              rx_service_field,
    input  wire logic                    rx_length_valid,
    input  wire logic [15:0]             rx_length_field,
    input  wire logic                    rx_check_valid,
    input  wire logic [7:0]              rx_check_high,
    output logic                         modem_data_ready,
    output logic                         search_active,
    output logic                         search_timeout,
    output logic [7:0]                   tx_signal_code,
    output logic                         rx_rate_is_bpsk,
    output logic                         rx_rate_is_qpsk,
    output logic                         length_count_usec
);
    logic [7:0]            modem_config_e_q;
    logic [7:0]            delimiter_search_time_q;
    logic [7:0]            bpsk_signal_code_q;
    logic [7:0]            qpsk_signal_code_q;
    logic [7:0]            rx_service_value_q;
    logic [7:0]            rx_length_high_q;
    logic [7:0]            rx_length_low_q;
    logic [7:0]            rx_header_check_high_q;
    logic                  awready_q;
    logic                  wready_q;
    logic                  bvalid_q;
    logic [1:0]            bresp_q;
    logic                  arready_q;
    logic                  rvalid_q;
    logic [1:0]            rresp_q;
    logic [DATA_WIDTH-1:0] rdata_q;
    logic                  data_ready_q;
    logic [7:0]            tx_code_q;
    logic                  rx_bpsk_q;
    logic                  rx_qpsk_q;
    logic                  usec_q;

    search_if srch ();

    delimiter_search_timer u_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .srch    (srch)
    );

    assign srch.start       = header_start;
    assign srch.found       = start_frame_delimiter_found;
    assign srch.symbol_tick = symbol_tick;
    assign srch.limit       = delimiter_search_time_q; // see [R3]

    // Write decode: both channels are taken together once both are offered.
    wire       wr_offer  = s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
    wire       wr_fire   = s_axi_awvalid && awready_q && s_axi_wvalid && wready_q;
    wire       wr_lane   = s_axi_wstrb[0];
    wire [7:0] wr_byte   = s_axi_wdata[7:0];
    wire [7:0] wr_addr   = s_axi_awaddr;
    wire       wr_cfg    = wr_fire && wr_lane && (wr_addr == MODEM_CONFIG_E_OFFSET);
    wire       wr_search = wr_fire && wr_lane && (wr_addr == SEARCH_TIME_OFFSET);
    wire       wr_bpsk   = wr_fire && wr_lane && (wr_addr == BPSK_CODE_OFFSET);
    wire       wr_qpsk   = wr_fire && wr_lane && (wr_addr == QPSK_CODE_OFFSET);
    wire       wr_rw_hit = (wr_addr == MODEM_CONFIG_E_OFFSET) ||
                           (wr_addr == SEARCH_TIME_OFFSET) ||
                           (wr_addr == BPSK_CODE_OFFSET) || (wr_addr == QPSK_CODE_OFFSET);
    wire       wr_ro_hit = (wr_addr == RX_SERVICE_OFFSET) ||
                           (wr_addr == RX_LENGTH_HIGH_OFFSET) ||
                           (wr_addr == RX_LENGTH_LOW_OFFSET) ||
                           (wr_addr == RX_CHECK_HIGH_OFFSET);
    wire [1:0] wr_resp   = (wr_rw_hit || wr_ro_hit) ? RESP_OKAY : RESP_SLVERR;

    // Read decode.
    wire       rd_offer  = s_axi_arvalid && !arready_q && !rvalid_q;
    wire       rd_fire   = s_axi_arvalid && arready_q;
    wire [7:0] rd_addr   = s_axi_araddr;
    wire       wr_rw_hit_rd = (rd_addr == MODEM_CONFIG_E_OFFSET) ||
                           (rd_addr == SEARCH_TIME_OFFSET) ||
                           (rd_addr == BPSK_CODE_OFFSET) || (rd_addr == QPSK_CODE_OFFSET);
    wire       rd_hit    = wr_rw_hit_rd || (rd_addr == RX_SERVICE_OFFSET) ||
                           (rd_addr == RX_LENGTH_HIGH_OFFSET) ||
                           (rd_addr == RX_LENGTH_LOW_OFFSET) ||
                           (rd_addr == RX_CHECK_HIGH_OFFSET);
    wire [7:0] rd_byte   =
        (rd_addr == MODEM_CONFIG_E_OFFSET) ? modem_config_e_q :
        (rd_addr == SEARCH_TIME_OFFSET)    ? delimiter_search_time_q :
        (rd_addr == BPSK_CODE_OFFSET)      ? bpsk_signal_code_q :
        (rd_addr == QPSK_CODE_OFFSET)      ? qpsk_signal_code_q :
        (rd_addr == RX_SERVICE_OFFSET)     ? rx_service_value_q :
        (rd_addr == RX_LENGTH_HIGH_OFFSET) ? rx_length_high_q :
        (rd_addr == RX_LENGTH_LOW_OFFSET)  ? rx_length_low_q :
        (rd_addr == RX_CHECK_HIGH_OFFSET)  ? rx_header_check_high_q : 8'h00;

    // Modem-side decisions.
    wire verify_en   = modem_config_e_q[VERIFY_READY_BIT];
    wire ready_set   = (verify_en && antenna_dwell_done) ||
                       start_frame_delimiter_found; // see [R1]
    wire ready_d     = ready_set || (data_ready_q && !rx_end);
    wire [7:0] code_d = tx_rate_qpsk ? qpsk_signal_code_q : bpsk_signal_code_q; // see [R4] [R5]
    wire is_bpsk     = (rx_signal_field == bpsk_signal_code_q); // see [R4]
    wire is_qpsk     = (rx_signal_field == qpsk_signal_code_q); // see [R5]
    // Reserved configuration bits are never stored and always read zero.
    wire [7:0] cfg_d = wr_byte & CONFIG_WRITE_MASK; // see [R2]

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            modem_config_e_q        <= CONFIG_RESET;
            delimiter_search_time_q <= SEARCH_TIME_RESET;
            bpsk_signal_code_q      <= BPSK_CODE_RESET;
            qpsk_signal_code_q      <= QPSK_CODE_RESET;
        end
        else
        begin
            if (wr_cfg)
                modem_config_e_q <= cfg_d;
            if (wr_search)
                delimiter_search_time_q <= wr_byte;
            if (wr_bpsk)
                bpsk_signal_code_q <= wr_byte;
            if (wr_qpsk)
                qpsk_signal_code_q <= wr_byte;
        end
    end

    // Received header fields are caught on every cycle their valid is high and held otherwise.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_service_value_q     <= STATUS_RESET;
            rx_length_high_q       <= STATUS_RESET;
            rx_length_low_q        <= STATUS_RESET;
            rx_header_check_high_q <= STATUS_RESET;
        end
        else
        begin
            if (rx_service_valid)
                rx_service_value_q <= rx_service_field; // see [R6] [R9]
            if (rx_length_valid)
            begin
                rx_length_high_q <= rx_length_field[15:8]; // see [R7] [R9]
                rx_length_low_q  <= rx_length_field[7:0]; // see [R7]
            end
            if (rx_check_valid)
                rx_header_check_high_q <= rx_check_high;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            data_ready_q <= 1'b0;
            tx_code_q    <= BPSK_CODE_RESET;
            rx_bpsk_q    <= 1'b0;
            rx_qpsk_q    <= 1'b0;
            usec_q       <= 1'b0;
        end
        else
        begin
            data_ready_q <= ready_d;
            tx_code_q    <= code_d;
            if (rx_signal_valid)
            begin
                rx_bpsk_q <= is_bpsk;
                rx_qpsk_q <= is_qpsk;
            end
            usec_q <= modem_config_e_q[LENGTH_USEC_BIT]; // see [R8]
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= '0;
        end
        else
        begin
            awready_q <= wr_offer;
            wready_q  <= wr_offer;
            if (wr_fire)
            begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_resp;
            end
            else if (s_axi_bready)
                bvalid_q <= 1'b0;
            arready_q <= rd_offer;
            if (rd_fire)
            begin
                rvalid_q <= 1'b1;
                rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                rdata_q  <= {{(DATA_WIDTH-8){1'b0}}, rd_byte};
            end
            else if (s_axi_rready)
                rvalid_q <= 1'b0;
        end
    end

    assign s_axi_awready     = awready_q;
    assign s_axi_wready      = wready_q;
    assign s_axi_bvalid      = bvalid_q;
    assign s_axi_bresp       = bresp_q;
    assign s_axi_arready     = arready_q;
    assign s_axi_rvalid      = rvalid_q;
    assign s_axi_rresp       = rresp_q;
    assign s_axi_rdata       = rdata_q;
    assign modem_data_ready  = data_ready_q;
    assign search_active     = srch.active;
    assign search_timeout    = srch.timeout;
    assign tx_signal_code    = tx_code_q;
    assign rx_rate_is_bpsk   = rx_bpsk_q;
    assign rx_rate_is_qpsk   = rx_qpsk_q;
    assign length_count_usec = usec_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_VERIFY_READY: assert property ( // see [R1]
        modem_config_e_q[VERIFY_READY_BIT] && antenna_dwell_done |=> modem_data_ready)
        else $error("Data ready not raised after antenna dwell.");
    AST_RSVD_ZERO: assert property ( // see [R2]
        wr_cfg |=> modem_config_e_q[0] == 1'b0 && modem_config_e_q[7] == 1'b0)
        else $error("Reserved configuration bit was stored.");
    AST_BPSK_TX: assert property ( // see [R4]
        !tx_rate_qpsk && !wr_bpsk |=> tx_signal_code == bpsk_signal_code_q)
        else $error("BPSK signalling code not driven.");
    AST_QPSK_RX: assert property ( // see [R5]
        rx_signal_valid && rx_signal_field == qpsk_signal_code_q && !wr_qpsk
        |=> rx_rate_is_qpsk)
        else $error("QPSK code not recognised.");
    AST_SERVICE_CAPTURE: assert property ( // see [R6]
        rx_service_valid |=> rx_service_value_q == $past(rx_service_field))
        else $error("Service field not captured.");
    AST_LENGTH_SPLIT: assert property ( // see [R7]
        rx_length_valid |=> {rx_length_high_q, rx_length_low_q} == $past(rx_length_field))
        else $error("Length field not split correctly.");
    AST_USEC_MODE: assert property ( // see [R8]
        wr_cfg && cfg_d[LENGTH_USEC_BIT] |=> ##1 length_count_usec)
        else $error("Microsecond length mode not applied.");
    AST_LENGTH_HOLD: assert property ( // see [R9]
        !rx_length_valid |=> $stable(rx_length_high_q) && $stable(rx_length_low_q))
        else $error("Length status changed without a header.");
    COV_WRITE: cover property (wr_fire);
    COV_READ: cover property (rd_fire ##1 rvalid_q);
    COV_VERIFY: cover property (verify_en && antenna_dwell_done);
endmodule

// File: axi_host_model.sv
// Host controller model: an AXI4-Lite master that runs one register access per task call.
`timescale 1ns/1ps
module axi_host_model
    import header_field_pkg::*;
(
    input  wire logic        aclk,
    output logic [7:0]       s_axi_awaddr  = 8'h00,
    output logic             s_axi_awvalid = 1'b0,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata   = 32'h0,
    output logic [3:0]       s_axi_wstrb   = 4'h0,
    output logic             s_axi_wvalid  = 1'b0,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready  = 1'b0,
    output logic [7:0]       s_axi_araddr  = 8'h00,
    output logic             s_axi_arvalid = 1'b0,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready  = 1'b0
);
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d, input int slow,
                             output logic [1:0] r);
        logic aw_open;
        logic w_open;
        aw_open = 1'b1;
        w_open = 1'b1;
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= (a == MODEM_CONFIG_E_OFFSET) ? (d & 32'hFFFF_FFFE) : d;
        s_axi_wstrb   <= 4'hF;
        s_axi_wvalid  <= 1'b1;
        while (aw_open || w_open)
        begin
            @(posedge aclk);
            if (aw_open && s_axi_awready)
            begin
                aw_open = 1'b0;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~a;
            end
            if (w_open && s_axi_wready)
            begin
                w_open = 1'b0;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~s_axi_wdata;
            end
        end
        repeat (slow) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do
            @(posedge aclk);
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
    endtask

    task automatic read_reg(input logic [7:0] a, input int slow, output logic [31:0] d,
                            output logic [1:0] r);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do
            @(posedge aclk);
        while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
        repeat (slow) @(posedge aclk);
        s_axi_rready <= 1'b1;
        do
            @(posedge aclk);
        while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
endmodule

// File: testbench.sv
// Self-checking testbench for the header field registers.
`timescale 1ns/1ps
module testbench;
    import header_field_pkg::*;
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
        logic [1:0] resp;
    } row_type;
    localparam row_type ROWS [21] = '{
        '{1'b0, 8'h9C, 8'h00, RESP_OKAY}, '{1'b0, 8'hA4, 8'h00, RESP_OKAY},
        '{1'b0, 8'hA8, 8'h0A, RESP_OKAY}, '{1'b0, 8'hAC, 8'h14, RESP_OKAY},
        '{1'b0, 8'hB0, 8'h00, RESP_OKAY}, '{1'b0, 8'hB4, 8'h00, RESP_OKAY},
        '{1'b0, 8'hB8, 8'h00, RESP_OKAY}, '{1'b0, 8'hBC, 8'h00, RESP_OKAY},
        '{1'b0, 8'hA0, 8'h00, RESP_SLVERR}, '{1'b0, 8'hC0, 8'h00, RESP_SLVERR},
        '{1'b1, 8'h9C, 8'hFF, RESP_OKAY}, '{1'b1, 8'hA4, 8'h05, RESP_OKAY},
        '{1'b1, 8'hA8, 8'h33, RESP_OKAY}, '{1'b1, 8'hAC, 8'h44, RESP_OKAY},
        '{1'b1, 8'hB0, 8'h77, RESP_OKAY}, '{1'b1, 8'hA0, 8'h11, RESP_SLVERR},
        '{1'b0, 8'h9C, 8'h7E, RESP_OKAY}, '{1'b0, 8'hA4, 8'h05, RESP_OKAY},
        '{1'b0, 8'hA8, 8'h33, RESP_OKAY}, '{1'b0, 8'hAC, 8'h44, RESP_OKAY},
        '{1'b0, 8'hB0, 8'h00, RESP_OKAY}};
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        antenna_dwell_done = 1'b0, header_start = 1'b0, symbol_tick = 1'b0;
    logic        start_frame_delimiter_found = 1'b0, rx_end = 1'b0, tx_rate_qpsk = 1'b0;
    logic        rx_signal_valid = 1'b0, rx_service_valid = 1'b0, rx_length_valid = 1'b0;
    logic        rx_check_valid = 1'b0;
    logic [7:0]  rx_signal_field = 8'h00, rx_service_field = 8'h00, rx_check_high = 8'h00;
    logic [15:0] rx_length_field = 16'h0000;
    logic        modem_data_ready, search_active, search_timeout;
    logic        rx_rate_is_bpsk, rx_rate_is_qpsk, length_count_usec;
    logic [7:0]  tx_signal_code;
    logic [7:0]  codes [3] = '{8'h44, 8'h33, 8'h55};
    logic [1:0]  rates [3] = '{2'b10, 2'b01, 2'b00};
    logic [31:0] rd;
    logic [1:0]  resp;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          n;

    header_field_registers header_field_registers_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .antenna_dwell_done(antenna_dwell_done), .header_start(header_start),
        .start_frame_delimiter_found(start_frame_delimiter_found), .symbol_tick(symbol_tick),
        .rx_end(rx_end), .tx_rate_qpsk(tx_rate_qpsk), .rx_signal_valid(rx_signal_valid),
        .rx_signal_field(rx_signal_field), .rx_service_valid(rx_service_valid),
        .rx_service_field(rx_service_field), .rx_length_valid(rx_length_valid),
        .rx_length_field(rx_length_field), .rx_check_valid(rx_check_valid),
        .rx_check_high(rx_check_high), .modem_data_ready(modem_data_ready),
        .search_active(search_active), .search_timeout(search_timeout),
        .tx_signal_code(tx_signal_code), .rx_rate_is_bpsk(rx_rate_is_bpsk),
        .rx_rate_is_qpsk(rx_rate_is_qpsk), .length_count_usec(length_count_usec));

    axi_host_model axi_host_model_i (.aclk(aclk),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    always #12.5 aclk = ~aclk;

    task automatic give_verdict();
        if (mismatches == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        axi_host_model_i.read_reg(a, 1, rd, resp);
        check(rd, {24'h0, exp});
        check(resp, RESP_OKAY);
    endtask

    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check(tx_signal_code, BPSK_CODE_RESET);
        check(modem_data_ready, 1'b0);
        foreach (ROWS[i])
        begin
            if (ROWS[i].wr)
                axi_host_model_i.write_reg(ROWS[i].addr, {24'hA5A5A5, ROWS[i].data}, i % 2, resp);
            else
                axi_host_model_i.read_reg(ROWS[i].addr, i % 2, rd, resp);
            if (!ROWS[i].wr)
                check(rd, {24'h0, ROWS[i].data});
            check(resp, ROWS[i].resp);
        end
        tx_rate_qpsk <= 1'b1;
        repeat (2) @(posedge aclk);
        check(tx_signal_code, 8'h44);
        tx_rate_qpsk <= 1'b0;
        repeat (2) @(posedge aclk);
        check(tx_signal_code, 8'h33);
        foreach (codes[i])
        begin
            rx_signal_field <= codes[i];
            rx_signal_valid <= 1'b1;
            @(posedge aclk);
            rx_signal_valid <= 1'b0;
            @(posedge aclk);
            check({rx_rate_is_qpsk, rx_rate_is_bpsk}, rates[i]);
        end
        rx_service_field <= 8'h5A;
        rx_length_field  <= 16'h1234;
        rx_check_high    <= 8'hC3;
        rx_service_valid <= 1'b1;
        rx_length_valid  <= 1'b1;
        rx_check_valid   <= 1'b1;
        @(posedge aclk);
        rx_service_field <= 8'hA5;
        rx_length_field  <= 16'hFEDC;
        rx_check_high    <= 8'h3C;
        rx_service_valid <= 1'b0;
        rx_check_valid   <= 1'b0;
        @(posedge aclk);
        rx_length_valid  <= 1'b0;
        reg_rd(RX_SERVICE_OFFSET, 8'h5A);
        reg_rd(RX_LENGTH_HIGH_OFFSET, 8'hFE);
        reg_rd(RX_LENGTH_LOW_OFFSET, 8'hDC);
        reg_rd(RX_CHECK_HIGH_OFFSET, 8'hC3);
        check(length_count_usec, 1'b1);
        antenna_dwell_done <= 1'b1;
        @(posedge aclk);
        antenna_dwell_done <= 1'b0;
        @(posedge aclk);
        check(modem_data_ready, 1'b1);
        rx_end <= 1'b1;
        @(posedge aclk);
        rx_end <= 1'b0;
        @(posedge aclk);
        check(modem_data_ready, 1'b0);
        axi_host_model_i.write_reg(MODEM_CONFIG_E_OFFSET, 32'h0, 0, resp);
        @(posedge aclk);
        check(length_count_usec, 1'b0);
        antenna_dwell_done <= 1'b1;
        @(posedge aclk);
        antenna_dwell_done <= 1'b0;
        repeat (2) @(posedge aclk);
        check(modem_data_ready, 1'b0);
        header_start <= 1'b1;
        symbol_tick  <= 1'b1;
        @(posedge aclk);
        header_start <= 1'b0;
        n = 0;
        while (search_timeout !== 1'b1 && n < 40)
        begin
            @(posedge aclk);
            n++;
            if (n == 2)
                check(search_active, 1'b1);
        end
        check(n >= 4 && n <= 7, 1'b1);
        repeat (2) @(posedge aclk);
        check(search_active, 1'b0);
        header_start <= 1'b1;
        @(posedge aclk);
        header_start <= 1'b0;
        repeat (2) @(posedge aclk);
        start_frame_delimiter_found <= 1'b1;
        @(posedge aclk);
        start_frame_delimiter_found <= 1'b0;
        n = 0;
        repeat (12)
        begin
            @(posedge aclk);
            n += (search_timeout === 1'b1);
        end
        symbol_tick <= 1'b0;
        check(n, 0);
        check(search_active, 1'b0);
        check(modem_data_ready, 1'b1);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check(modem_data_ready, 1'b0);
        reg_rd(BPSK_CODE_OFFSET, BPSK_CODE_RESET);
        reg_rd(RX_LENGTH_HIGH_OFFSET, STATUS_RESET);
        give_verdict();
    end
endmodule
